// ### hw/msc_defs.svh
// constants of the music synthesizer control block
// assumes a 50 MHz clock and active-low pushbuttons
`ifndef MSC_DEFS_SVH
`define MSC_DEFS_SVH
`define MSC_CLK_HZ 50000000
`define MSC_DEB_MS 10
`define MSC_NOTE_MS 250
`define MSC_PS2_IDLE 12'hfff
`define MSC_HALF_BASE 36'h20fdf
`define MSC_SEMI_MUL 36'h3c68
`define MSC_SEMI_SHIFT 14
`define MSC_NKEYS 19
`define MSC_REST 5'h1f
`define MSC_BRK 8'hf0
`define MSC_EXT 8'he0
`define MSC_A_CTRL 4'h0
`define MSC_A_STAT 4'h4
`define MSC_A_KEYS 4'h8
`define MSC_CTRL_LOOP 0
`define MSC_H_TOT 10'h31f
`define MSC_H_SY0 10'h290
`define MSC_H_SY1 10'h2ef
`define MSC_H_KEYS 10'h260
`define MSC_V_TOT 10'h20c
`define MSC_V_SY0 10'h1ea
`define MSC_V_SY1 10'h1eb
`define MSC_V_KY0 10'h0c8
`define MSC_V_KY1 10'h117
`endif

// ### hw/msc_pkg.sv
// types of the music synthesizer control block
// assumes msc_defs.svh for the numbers
package msc_pkg;
    typedef struct packed {
        logic source;
        logic ch2_en;
        logic ch1_en;
        logic timbre;
    } msc_sw_t;
    typedef struct packed {
        logic hs;
        logic vs;
        logic r;
        logic g;
        logic b;
    } msc_vga_t;
    typedef enum logic [1:0] {MSC_D_IDLE = 2'b00, MSC_D_PLAY = 2'b01} msc_demo_t;
endpackage

// ### hw/msc_top.sv
// music synthesizer control: keyboard, demo tune, tone, vga key painter
// assumes pins are asynchronous, one 50 MHz clock, plain register port
// Behaviour
// R1 - switch off demo tune, on keyboard
// R2 - replay button restarts demo from start
// R3 - timbre switch: off brass, on string
// R4 - two audio channels, each own enable
// R5 - reset button returns whole circuit initial; vga counters, debounce and pin sync stages are not cleared by it
// R6 - letter keys map to nineteen notes
// R7 - vga shows keyboard, pressed keys lit
// R8 - stored tune plays back note sequence
// R9 - ps2 key presses become played notes
// R10 - user sets all switches low first
// R11 - buttons debounced, one action per press
`timescale 1ns/1ns
`include "msc_defs.svh"
module msc_top import msc_pkg::*; #(
    parameter int DEB_CYC = `MSC_CLK_HZ / 1000 * `MSC_DEB_MS,
    parameter int NOTE_CYC = `MSC_CLK_HZ / 1000 * `MSC_NOTE_MS
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic reset_pushbutton_b,
    input wire logic replay_pushbutton_b,
    input wire msc_sw_t sw,
    input wire logic ps2_clk,
    input wire logic ps2_data,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic aud_ch1,
    output logic aud_ch2,
    output msc_vga_t vga
);
    // ==========================================================
    // pin synchronisers
    logic [7:0] pin_w, s1_r, s2_r, s3_r, f_r;
    assign pin_w = {sw, ps2_data, ps2_clk, replay_pushbutton_b, reset_pushbutton_b};
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s1_r <= 8'h0f;
            s2_r <= 8'h0f;
            s3_r <= 8'h0f;
            f_r <= 8'h0f;
        end else begin
            s1_r <= pin_w;
            s2_r <= s1_r;
            s3_r <= s2_r;
            for (int i = 0; i < 8; i++) begin
                if (s2_r[i] == s3_r[i]) f_r[i] <= s3_r[i];
            end
        end
    end
    msc_sw_t swf;
    assign swf = f_r[7:4];

    // ==========================================================
    // pushbutton debounce
    logic [1:0] btn_st_r, press_r;
    logic [23:0] deb_r [2];
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            btn_st_r <= 2'h3;
            press_r <= 2'h0;
            deb_r[0] <= 24'h0;
            deb_r[1] <= 24'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                press_r[i] <= 1'b0;
                if (f_r[i] == btn_st_r[i]) begin
                    deb_r[i] <= 24'h0;
                end else if (deb_r[i] == 24'(DEB_CYC - 1)) begin
                    deb_r[i] <= 24'h0;
                    btn_st_r[i] <= f_r[i];
                    press_r[i] <= ~f_r[i]; // [R11]
                end else begin
                    deb_r[i] <= deb_r[i] + 24'h1;
                end
            end
        end
    end
    logic srst, replay;
    assign srst = press_r[0]; // [R5]
    assign replay = press_r[1];

    // ==========================================================
    // ps2 key press receiver
    function automatic logic [4:0] key_idx(input logic [7:0] c);
        case (c)
            8'h15: key_idx = 5'd0;
            8'h1c: key_idx = 5'd1;
            8'h1d: key_idx = 5'd2;
            8'h1b: key_idx = 5'd3;
            8'h24: key_idx = 5'd4;
            8'h23: key_idx = 5'd5;
            8'h2b: key_idx = 5'd6;
            8'h2c: key_idx = 5'd7;
            8'h34: key_idx = 5'd8;
            8'h35: key_idx = 5'd9;
            8'h33: key_idx = 5'd10;
            8'h3b: key_idx = 5'd11;
            8'h43: key_idx = 5'd12;
            8'h42: key_idx = 5'd13;
            8'h44: key_idx = 5'd14;
            8'h4b: key_idx = 5'd15;
            8'h4d: key_idx = 5'd16;
            8'h4c: key_idx = 5'd17;
            8'h52: key_idx = 5'd18;
            default: key_idx = `MSC_REST;
        endcase
    endfunction
    logic pc_d_r, brk_r, code_v;
    logic [3:0] bit_r;
    logic [10:0] sh_r, frm;
    logic [11:0] idle_r;
    logic [18:0] keys_r;
    logic [4:0] live_r, kidx;
    assign frm = {f_r[3], sh_r[10:1]};
    assign kidx = key_idx(frm[8:1]);
    assign code_v = (bit_r == 4'd10) && !frm[0] && frm[10] && ^frm[9:1];
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pc_d_r <= 1'b1;
            bit_r <= 4'h0;
            sh_r <= 11'h0;
            idle_r <= 12'h0;
        end else if (srst) begin
            bit_r <= 4'h0;
            idle_r <= 12'h0;
        end else begin
            pc_d_r <= f_r[2];
            if (pc_d_r && !f_r[2]) begin
                idle_r <= 12'h0;
                sh_r <= frm;
                bit_r <= (bit_r == 4'd10) ? 4'h0 : bit_r + 4'h1;
            end else if (idle_r == `MSC_PS2_IDLE) begin
                bit_r <= 4'h0;
            end else begin
                idle_r <= idle_r + 12'h1;
            end
        end
    end
    logic key_ev;
    assign key_ev = pc_d_r && !f_r[2] && code_v;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            brk_r <= 1'b0;
            keys_r <= 19'h0;
            live_r <= `MSC_REST;
        end else if (srst) begin
            brk_r <= 1'b0;
            keys_r <= 19'h0;
            live_r <= `MSC_REST;
        end else if (key_ev) begin
            if (frm[8:1] == `MSC_BRK) begin
                brk_r <= 1'b1;
            end else if (frm[8:1] != `MSC_EXT) begin
                brk_r <= 1'b0;
                if (kidx != `MSC_REST) begin
                    keys_r[kidx] <= !brk_r; // [R6]
                    if (!brk_r) live_r <= kidx; // [R9]
                    else if (live_r == kidx) live_r <= `MSC_REST;
                end
            end
        end
    end

    // ==========================================================
    // demo tune store and sequencer
    localparam logic [4:0] TUNE [16] = '{5'd6, 5'd6, 5'd13, 5'd13, 5'd15, 5'd15, 5'd13,
        5'h1f, 5'd11, 5'd11, 5'd10, 5'd10, 5'd8, 5'd8, 5'd6, 5'h1f};
    msc_demo_t demo_r;
    logic [3:0] didx_r;
    logic [23:0] tick_r;
    logic loop_r;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            demo_r <= MSC_D_IDLE;
            didx_r <= 4'h0;
            tick_r <= 24'h0;
        end else if (srst) begin
            demo_r <= MSC_D_IDLE;
            didx_r <= 4'h0;
            tick_r <= 24'h0;
        end else if (replay) begin
            demo_r <= MSC_D_PLAY; // [R2]
            didx_r <= 4'h0;
            tick_r <= 24'h0;
        end else begin
            case (demo_r)
                MSC_D_PLAY: begin
                    if (tick_r == 24'(NOTE_CYC - 1)) begin
                        tick_r <= 24'h0;
                        didx_r <= didx_r + 4'h1; // [R8]
                        if (didx_r == 4'hf && !loop_r) demo_r <= MSC_D_IDLE;
                    end else begin
                        tick_r <= tick_r + 24'h1;
                    end
                end
                default: demo_r <= MSC_D_IDLE;
            endcase
        end
    end
    logic [4:0] demo_note;
    assign demo_note = (demo_r == MSC_D_PLAY) ? TUNE[didx_r] : `MSC_REST;

    // ==========================================================
    // voice synthesis core
    function automatic logic [17:0] half_f(input int n);
        logic [35:0] h;
        h = `MSC_HALF_BASE;
        for (int i = 0; i < n; i++) h = (h * `MSC_SEMI_MUL) >> `MSC_SEMI_SHIFT;
        return h[17:0];
    endfunction
    logic [17:0] half_tab [`MSC_NKEYS];
    for (genvar g = 0; g < `MSC_NKEYS; g++) begin : g_half
        localparam logic [17:0] HALF = half_f(g);
        assign half_tab[g] = HALF;
    end
    logic [4:0] note_r;
    logic [18:0] ph_r;
    logic [17:0] half;
    logic wave;
    assign half = (note_r < 5'(`MSC_NKEYS)) ? half_tab[note_r] : 18'h0;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            note_r <= `MSC_REST;
        end else if (srst) begin
            note_r <= `MSC_REST;
        end else begin
            note_r <= swf.source ? live_r : demo_note; // [R1]
        end
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ph_r <= 19'h0;
        end else if (srst || note_r == `MSC_REST || ph_r >= {half, 1'b0} - 19'h1) begin
            ph_r <= 19'h0;
        end else begin
            ph_r <= ph_r + 19'h1;
        end
    end
    // string is a narrow pulse, brass a square
    assign wave = (note_r != `MSC_REST) &&
        (swf.timbre ? (ph_r < {3'h0, half[17:2]}) : (ph_r < {1'b0, half})); // [R3]
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            aud_ch1 <= 1'b0;
            aud_ch2 <= 1'b0;
        end else begin
            aud_ch1 <= wave && swf.ch1_en; // [R4]
            aud_ch2 <= wave && swf.ch2_en; // [R4]
        end
    end

    // ==========================================================
    // note display painter
    logic pix_r;
    logic [9:0] hc_r, vc_r;
    logic [18:0] lit;
    logic inbox, on;
    assign lit = keys_r | ((note_r < 5'(`MSC_NKEYS)) ? (19'h1 << note_r) : 19'h0);
    assign inbox = hc_r < `MSC_H_KEYS && vc_r >= `MSC_V_KY0 && vc_r <= `MSC_V_KY1 &&
        hc_r[4:0] != 5'h0;
    assign on = inbox && lit[hc_r[9:5]];
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pix_r <= 1'b0;
            hc_r <= 10'h0;
            vc_r <= 10'h0;
            vga <= '{hs: 1'b1, vs: 1'b1, default: 1'b0};
        end else begin
            pix_r <= !pix_r;
            if (pix_r) begin
                hc_r <= (hc_r == `MSC_H_TOT) ? 10'h0 : hc_r + 10'h1;
                if (hc_r == `MSC_H_TOT) vc_r <= (vc_r == `MSC_V_TOT) ? 10'h0 : vc_r + 10'h1;
                vga.hs <= !(hc_r >= `MSC_H_SY0 && hc_r <= `MSC_H_SY1);
                vga.vs <= !(vc_r >= `MSC_V_SY0 && vc_r <= `MSC_V_SY1);
                vga.r <= inbox; // [R7]
                vga.g <= inbox && !on;
                vga.b <= inbox && !on;
            end
        end
    end

    // ==========================================================
    // register port
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            loop_r <= 1'b0;
            reg_rdata <= 32'h0;
        end else begin
            if (srst) loop_r <= 1'b0;
            else if (reg_wr && reg_addr == `MSC_A_CTRL) loop_r <= reg_wdata[`MSC_CTRL_LOOP];
            reg_rdata <= 32'h0;
            if (reg_rd) begin
                case (reg_addr)
                    `MSC_A_CTRL: reg_rdata <= {31'h0, loop_r};
                    `MSC_A_STAT: reg_rdata <= {16'h0, swf, 1'b0, demo_r[0], didx_r, 1'b0, note_r};
                    `MSC_A_KEYS: reg_rdata <= {13'h0, keys_r};
                    default: reg_rdata <= 32'h0;
                endcase
            end
        end
    end

    // ==========================================================
    // checks
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    src_demo_a: assert property (!srst && !swf.source && $stable(demo_note) |=> // [R1]
        note_r == $past(demo_note)) else $error("demo note not selected");
    replay_start_a: assert property (replay && !srst |=> // [R2]
        demo_r == MSC_D_PLAY && didx_r == 4'h0) else $error("replay did not restart");
    string_duty_a: assert property (swf.timbre && ph_r >= {3'h0, half[17:2]} |-> // [R3]
        !wave) else $error("string pulse too wide");
    ch_gate_a: assert property (aud_ch1 |-> $past(swf.ch1_en)) // [R4]
        else $error("channel one played while off");
    ch_two_a: assert property (aud_ch2 |-> $past(swf.ch2_en)) // [R4]
        else $error("channel two played while off");
    soft_reset_a: assert property (srst |=> demo_r == MSC_D_IDLE && keys_r == 19'h0 && // [R5]
        note_r == `MSC_REST) else $error("reset button left state");
    key_make_a: assert property (key_ev && !brk_r && !srst && frm[8:1] == 8'h1c |=> // [R6]
        keys_r[1] && live_r == 5'd1) else $error("key a not mapped");
    paint_lit_a: assert property (pix_r && on |=> vga.r && !vga.g) // [R7]
        else $error("pressed key not lit");
    hsync_low_a: assert property (pix_r && hc_r == `MSC_H_SY0 |=> !vga.hs) // [R7]
        else $error("hsync pulse missing");
    demo_step_a: assert property (demo_r == MSC_D_PLAY && tick_r == 24'(NOTE_CYC - 1) && // [R8]
        !srst && !replay |=> didx_r == $past(didx_r) + 4'h1) else $error("demo did not step");
    press_once_a: assert property (press_r[1] |=> !press_r[1] [*2]) // [R11]
        else $error("double press pulse");
    replay_c: cover property (replay ##1 demo_r == MSC_D_PLAY);
    string_c: cover property (swf.timbre && aud_ch1);
    key_c: cover property (key_ev && !brk_r && kidx != `MSC_REST);
endmodule // msc_top

// ### tb/msc_kbd_model.sv
// key press source model: sends scan code frames on the ps2 pins
// assumes pulled-up lines, so both pins rest high between frames
`timescale 1ns/1ns
module msc_kbd_model #(
    parameter int HALF_NS = 400
) (
    output logic ps2_clk,
    output logic ps2_data
);
    initial begin
        ps2_clk = 1'b1;
        ps2_data = 1'b1;
    end
    // ==========
    // one frame: start, lsb first data, odd parity, stop
    task automatic send(input logic [7:0] b, input logic bad);
        logic [10:0] f;
        f = {1'b1, ~^b ^ bad, b, 1'b0};
        // stay off the clock edges
        #3;
        for (int i = 0; i < 11; i++) begin
            ps2_data = f[i];
            #(HALF_NS);
            ps2_clk = 1'b0;
            #(HALF_NS);
            ps2_clk = 1'b1;
        end
        ps2_data = 1'b1;
        #(HALF_NS * 4);
    endtask
endmodule // msc_kbd_model

// ### tb/tb_music_synth_control.sv
// testbench of the music synthesizer control block
// assumes shortened debounce and note lengths, register port reads
`timescale 1ns/1ns
`include "msc_defs.svh"
module tb_music_synth_control;
    import msc_pkg::*;
    localparam int DEB = 8;
    localparam int NOTE = 64;
    logic clk, rst_b, reset_pushbutton_b, replay_pushbutton_b, ps2_clk, ps2_data;
    logic reg_wr, reg_rd, aud_ch1, aud_ch2;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, d;
    msc_sw_t sw;
    msc_vga_t vga;
    int err_count = 0;
    int checks_done = 0;
    int k0;
    int hs_n;
    logic [7:0] codes [19] = '{8'h15, 8'h1c, 8'h1d, 8'h1b, 8'h24, 8'h23, 8'h2b, 8'h2c,
        8'h34, 8'h35, 8'h33, 8'h3b, 8'h43, 8'h42, 8'h44, 8'h4b, 8'h4d, 8'h4c, 8'h52};
    msc_top #(.DEB_CYC(DEB), .NOTE_CYC(NOTE)) DUT (.clk(clk), .rst_b(rst_b),
        .reset_pushbutton_b(reset_pushbutton_b), .replay_pushbutton_b(replay_pushbutton_b),
        .sw(sw), .ps2_clk(ps2_clk), .ps2_data(ps2_data), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .aud_ch1(aud_ch1), .aud_ch2(aud_ch2), .vga(vga));
    msc_kbd_model kbd (.ps2_clk(ps2_clk), .ps2_data(ps2_data));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // ==========
    // helpers
    function automatic logic [31:0] key_bit(input int i);
        return 32'h1 << i;
    endfunction
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task automatic press(input logic rep, input int n);
        @(posedge clk);
        if (rep) replay_pushbutton_b <= 1'b0;
        else reset_pushbutton_b <= 1'b0;
        repeat (n) @(posedge clk);
        replay_pushbutton_b <= 1'b1;
        reset_pushbutton_b <= 1'b1;
        repeat (20) @(posedge clk);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #(20 * 80000);
        err_count++;
        $display("watchdog expired");
        results;
    end
    // ==========
    // main sequence
    initial begin
        rst_b = 1'b0;
        reset_pushbutton_b = 1'b1;
        replay_pushbutton_b = 1'b1;
        sw = '0;
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        void'($urandom(32'h49fd));
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        rd(`MSC_A_STAT, d);
        chk("rest note", 32'(d[4:0]), `MSC_REST);
        chk("demo idle", 32'(d[10]), 0);
        wr(`MSC_A_CTRL, 32'h1);
        rd(`MSC_A_CTRL, d);
        chk("loop bit", d, 32'h1);
        wr(`MSC_A_CTRL, 32'h0);
        wr(4'hc, 32'hffffffff);
        rd(4'hc, d);
        chk("unmapped", d, 0);
        $display("register test done");
        for (int n = 0; n < 6; n++) begin
            @(posedge clk);
            sw <= msc_sw_t'($urandom);
            repeat (8) @(posedge clk);
            rd(`MSC_A_STAT, d);
            chk("switches", 32'(d[15:12]), 32'(sw));
            repeat (50) @(negedge clk);
            if (!sw.ch1_en) chk("ch1 off", 32'(aud_ch1), 0);
            if (!sw.ch2_en) chk("ch2 off", 32'(aud_ch2), 0);
        end
        $display("switch test done");
        @(posedge clk);
        sw <= 4'b1000;
        k0 = $urandom % 19;
        for (int k = 0; k < 19; k++) begin
            int i;
            i = (k0 + k * 7) % 19;
            @(posedge clk);
            sw <= {1'b1, 3'($urandom)};
            kbd.send(codes[i], 1'b0);
            rd(`MSC_A_KEYS, d);
            chk("key held", d, key_bit(i));
            rd(`MSC_A_STAT, d);
            chk("key note", 32'(d[4:0]), i);
            chk("ch1 wave", 32'(aud_ch1), 32'(sw.ch1_en));
            chk("ch2 wave", 32'(aud_ch2), 32'(sw.ch2_en));
            kbd.send(`MSC_BRK, 1'b0);
            kbd.send(codes[i], 1'b0);
            rd(`MSC_A_KEYS, d);
            chk("key gone", d, 0);
        end
        kbd.send(codes[3], 1'b1);
        rd(`MSC_A_KEYS, d);
        chk("bad frame", d, 0);
        // held high note: hsync timing, then string gap against brass level
        @(posedge clk);
        sw <= 4'b1111;
        kbd.send(codes[18], 1'b0);
        rd(`MSC_A_STAT, d);
        chk("high note", 32'(d[4:0]), 18);
        while (!vga.hs) @(negedge clk);
        while (vga.hs) @(negedge clk);
        hs_n = 0;
        while (!vga.hs) begin
            @(negedge clk);
            hs_n++;
        end
        chk("hsync width", hs_n, 2 * (`MSC_H_SY1 - `MSC_H_SY0 + 1));
        while (vga.hs) begin
            @(negedge clk);
            hs_n++;
        end
        chk("hsync period", hs_n, 2 * (`MSC_H_TOT + 1));
        repeat (12000) @(negedge clk);
        chk("string gap", 32'(aud_ch1), 0);
        @(posedge clk);
        sw <= 4'b1110;
        repeat (8) @(negedge clk);
        chk("brass level", 32'(aud_ch1), 1);
        chk("ch2 level", 32'(aud_ch2), 1);
        kbd.send(`MSC_EXT, 1'b0);
        kbd.send(`MSC_BRK, 1'b0);
        kbd.send(codes[18], 1'b0);
        rd(`MSC_A_KEYS, d);
        chk("ext release", d, 0);
        $display("keyboard test done");
        @(posedge clk);
        sw <= 4'b0000;
        press(1'b1, 3);
        rd(`MSC_A_STAT, d);
        chk("glitch", 32'(d[10]), 0);
        press(1'b1, 60);
        rd(`MSC_A_STAT, d);
        chk("one start", 32'(d[10:6]), 32'h11);
        press(1'b1, 20);
        rd(`MSC_A_STAT, d);
        chk("restart", 32'(d[10:6]), 32'h10);
        repeat (17 * NOTE) @(posedge clk);
        rd(`MSC_A_STAT, d);
        chk("tune end", 32'(d[10]), 0);
        $display("demo test done");
        @(posedge clk);
        sw <= 4'b1000;
        kbd.send(codes[8], 1'b0);
        press(1'b1, 20);
        wr(`MSC_A_CTRL, 32'h1);
        press(1'b0, 20);
        rd(`MSC_A_STAT, d);
        chk("soft idle", 32'({d[10], d[4:0]}), 32'(`MSC_REST));
        rd(`MSC_A_KEYS, d);
        chk("soft keys", d, 0);
        rd(`MSC_A_CTRL, d);
        chk("soft loop", d, 0);
        $display("reset button test done");
        results;
    end
endmodule // tb_music_synth_control
